// *** tsi_defines.svh ***
// register indices, field positions and reset values of the timer/serial interrupt block
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH

// register indices; the byte address is four times the index
`define TSI_IDX_SER_CTRL 6'h0a
`define TSI_IDX_SER_STAT 6'h0b
`define TSI_IDX_SER_DATA 6'h0c
`define TSI_IDX_TMR_CTRL 6'h12
`define TSI_IDX_TMR_STAT 6'h13
`define TSI_IDX_CAP_LOW  6'h15
`define TSI_IDX_CMP_LOW  6'h17
`define TSI_IDX_CNT_LOW  6'h19
`define TSI_IDX_EVT_STAT 6'h20
`define TSI_IDX_EVT_MASK 6'h21

// index field of haddr
`define TSI_ADDR_HI 7
`define TSI_ADDR_LO 2

// timer control and status fields
`define TSI_BIT_CAP 7
`define TSI_BIT_CMP 6
`define TSI_BIT_OVF 5

// serial control and status fields
`define TSI_BIT_SER_EN   7
`define TSI_BIT_SER_CLR  0
`define TSI_BIT_SER_DONE 7

// event status and mask fields
`define TSI_EVT_CAP 0
`define TSI_EVT_CMP 1
`define TSI_EVT_OVF 2
`define TSI_EVT_SER 3

// htrans bit that marks NONSEQ or SEQ
`define TSI_HTRANS_ACT 1

// reset values
`define TSI_RST_BYTE 8'h00
`define TSI_RST_EVT  4'h0
`define TSI_RST_TMR  3'h0
`define TSI_RST_WORD 32'h0000_0000
`define TSI_PAD_WIDTH 24

`endif

// *** tsi_pkg.sv ***
// types shared by the timer/serial interrupt block
package tsi_pkg;
   typedef logic [5:0] tsi_idx_t;
   typedef logic [7:0] tsi_byte_t;
   typedef logic [3:0] tsi_evt_t;
   typedef logic [2:0] tsi_tmr_t;
endpackage

// *** tsi_irq.sv ***
// timer and serial interrupt flags with an AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "tsi_defines.svh"

module tsi_irq
   import tsi_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        cpu_irq_mask,
   input  wire logic        capture_evt,
   input  wire logic        compare_evt,
   input  wire logic        overflow_evt,
   input  wire logic        serial_done_evt,
   input  wire logic [7:0]  capture_value,
   input  wire logic [7:0]  counter_value,
   input  wire logic [7:0]  serial_rx_data,
   output logic [7:0]       compare_low_byte,
   output logic [7:0]       serial_tx_data,
   output logic             serial_tx_load,
   output logic             timer_irq,
   output logic             serial_irq,
   output logic             event_irq
);

   // address phase decode
   logic      acc;
   logic      rd;
   logic      wr;
   tsi_idx_t  idx;
   tsi_byte_t rd_byte;

   // data phase of a write
   logic      wr_pend_q;
   tsi_idx_t  wr_idx_q;
   logic      wr_stb;
   tsi_byte_t wr_byte;

   // register state
   tsi_tmr_t  tmr_en_q;
   tsi_tmr_t  tmr_flag_q;
   tsi_tmr_t  tmr_arm_q;
   tsi_tmr_t  tmr_set;
   tsi_tmr_t  tmr_clr_acc;
   logic      ser_en_q;
   logic      ser_flag_q;
   logic      ser_arm_q;
   logic      ser_data_acc;
   logic      ser_w1c;
   tsi_byte_t cmp_low_q;
   tsi_byte_t tx_data_q;
   logic      tx_load_q;
   tsi_evt_t  evt;
   tsi_evt_t  evt_stat_q;
   tsi_evt_t  evt_mask_q;
   logic [31:0] hrdata_q;

   assign acc = hsel & hready & htrans[`TSI_HTRANS_ACT];
   assign rd  = acc & ~hwrite;
   assign wr  = acc & hwrite;
   assign idx = haddr[`TSI_ADDR_HI:`TSI_ADDR_LO];
   assign wr_stb  = wr_pend_q;
   assign wr_byte = hwdata[7:0];

   // every transfer completes with no wait state and an OKAY answer
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= '0;
      end else begin
         wr_pend_q <= wr;
         wr_idx_q  <= idx;
      end
   end

   // read mux, sampled at the address phase
   always_comb begin
      rd_byte = `TSI_RST_BYTE;
      unique case (idx)
         `TSI_IDX_SER_CTRL: begin
            rd_byte[`TSI_BIT_SER_EN] = ser_en_q;
         end
         `TSI_IDX_SER_STAT: begin
            rd_byte[`TSI_BIT_SER_DONE] = ser_flag_q;
         end
         `TSI_IDX_SER_DATA: begin
            rd_byte = serial_rx_data;
         end
         `TSI_IDX_TMR_CTRL: begin
            rd_byte[`TSI_BIT_CAP:`TSI_BIT_OVF] = tmr_en_q;
         end
         `TSI_IDX_TMR_STAT: begin
            rd_byte[`TSI_BIT_CAP:`TSI_BIT_OVF] = tmr_flag_q;
         end
         `TSI_IDX_CAP_LOW: begin
            rd_byte = capture_value;
         end
         `TSI_IDX_CMP_LOW: begin
            rd_byte = cmp_low_q;
         end
         `TSI_IDX_CNT_LOW: begin
            rd_byte = counter_value;
         end
         `TSI_IDX_EVT_STAT: begin
            rd_byte[3:0] = evt_stat_q;
         end
         `TSI_IDX_EVT_MASK: begin
            rd_byte[3:0] = evt_mask_q;
         end
         default: begin
            rd_byte = `TSI_RST_BYTE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         hrdata_q <= `TSI_RST_WORD;
      end else if (rd) begin
         hrdata_q <= {{`TSI_PAD_WIDTH{1'b0}}, rd_byte};
      end
   end

   // timer enables kept across reset, so no reset branch
   always_ff @(posedge clock) begin
      if (wr_stb && wr_idx_q == `TSI_IDX_TMR_CTRL) begin
         tmr_en_q <= wr_byte[`TSI_BIT_CAP:`TSI_BIT_OVF];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ser_en_q <= 1'b0;
      end else if (wr_stb && wr_idx_q == `TSI_IDX_SER_CTRL) begin
         ser_en_q <= wr_byte[`TSI_BIT_SER_EN];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cmp_low_q <= `TSI_RST_BYTE;
      end else if (wr_stb && wr_idx_q == `TSI_IDX_CMP_LOW) begin
         cmp_low_q <= wr_byte;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         tx_data_q <= `TSI_RST_BYTE;
         tx_load_q <= 1'b0;
      end else begin
         tx_load_q <= wr_stb && wr_idx_q == `TSI_IDX_SER_DATA;
         if (wr_stb && wr_idx_q == `TSI_IDX_SER_DATA) begin
            tx_data_q <= wr_byte;
         end
      end
   end

   assign compare_low_byte = cmp_low_q;
   assign serial_tx_data   = tx_data_q;
   assign serial_tx_load   = tx_load_q;

   // timer sources, highest bit capture, lowest overflow
   assign tmr_set = {capture_evt, compare_evt, overflow_evt};
   assign tmr_clr_acc[2] = rd && idx == `TSI_IDX_CAP_LOW;
   assign tmr_clr_acc[1] = acc && idx == `TSI_IDX_CMP_LOW;
   assign tmr_clr_acc[0] = acc && idx == `TSI_IDX_CNT_LOW;

   generate
      for (genvar i = 0; i < 3; i++) begin : g_tmr
         // a new event beats a clear in the same cycle
         always_ff @(posedge clock) begin
            if (srst) begin
               tmr_flag_q[i] <= 1'b0;
            end else if (tmr_set[i]) begin
               tmr_flag_q[i] <= 1'b1;
            end else if (tmr_arm_q[i] && tmr_clr_acc[i]) begin
               tmr_flag_q[i] <= 1'b0;
            end
         end

         always_ff @(posedge clock) begin
            if (srst) begin
               tmr_arm_q[i] <= 1'b0;
            end else if (rd && idx == `TSI_IDX_TMR_STAT) begin
               tmr_arm_q[i] <= tmr_flag_q[i];
            end else if (tmr_clr_acc[i]) begin
               tmr_arm_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign ser_data_acc = acc && idx == `TSI_IDX_SER_DATA;
   assign ser_w1c = wr_stb && wr_idx_q == `TSI_IDX_SER_CTRL && wr_byte[`TSI_BIT_SER_CLR];

   always_ff @(posedge clock) begin
      if (srst) begin
         ser_flag_q <= 1'b0;
      end else if (serial_done_evt) begin
         ser_flag_q <= 1'b1;
      end else if ((ser_arm_q && ser_data_acc) || ser_w1c) begin
         ser_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ser_arm_q <= 1'b0;
      end else if (rd && idx == `TSI_IDX_SER_STAT) begin
         ser_arm_q <= ser_flag_q;
      end else if (ser_data_acc) begin
         ser_arm_q <= 1'b0;
      end
   end

   // flags are sticky, so a masked request simply waits
   assign timer_irq  = |(tmr_flag_q & tmr_en_q) & ~cpu_irq_mask;
   assign serial_irq = ser_flag_q & ser_en_q & ~cpu_irq_mask;

   // sticky event log for system-level interrupt
   assign evt[`TSI_EVT_CAP] = capture_evt;
   assign evt[`TSI_EVT_CMP] = compare_evt;
   assign evt[`TSI_EVT_OVF] = overflow_evt;
   assign evt[`TSI_EVT_SER] = serial_done_evt;

   always_ff @(posedge clock) begin
      if (srst) begin
         evt_stat_q <= `TSI_RST_EVT;
      end else if (wr_stb && wr_idx_q == `TSI_IDX_EVT_STAT) begin
         evt_stat_q <= (evt_stat_q & ~wr_byte[3:0]) | evt;
      end else begin
         evt_stat_q <= evt_stat_q | evt;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         evt_mask_q <= `TSI_RST_EVT;
      end else if (wr_stb && wr_idx_q == `TSI_IDX_EVT_MASK) begin
         evt_mask_q <= wr_byte[3:0];
      end
   end

   assign event_irq = |(evt_stat_q & evt_mask_q);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   a_mask_blocks_timer: assert property (cpu_irq_mask |-> !timer_irq)
      else $error("timer request while global mask set");
   a_mask_blocks_serial: assert property (cpu_irq_mask |-> !serial_irq)
      else $error("serial request while global mask set");
   a_capture_request: assert property (
      capture_evt && !cpu_irq_mask ##1 tmr_en_q[2] && !cpu_irq_mask |-> timer_irq)
      else $error("capture flag with enable gave no request");
   a_compare_request: assert property (
      compare_evt ##1 tmr_en_q[1] && !cpu_irq_mask |-> timer_irq)
      else $error("compare flag with enable gave no request");
   a_overflow_request: assert property (
      overflow_evt ##1 tmr_en_q[0] && !cpu_irq_mask |-> timer_irq)
      else $error("overflow flag with enable gave no request");
   a_serial_request: assert property (
      serial_done_evt ##1 ser_en_q && !cpu_irq_mask |-> serial_irq)
      else $error("serial flag with enable gave no request");
   // clear sequences and their arming
   a_capture_clear: assert property (
      tmr_arm_q[2] && rd && idx == `TSI_IDX_CAP_LOW && !capture_evt |=> !tmr_flag_q[2])
      else $error("capture flag survived its clear sequence");
   a_capture_write_keeps: assert property (
      tmr_flag_q[2] && wr && idx == `TSI_IDX_CAP_LOW |=> tmr_flag_q[2])
      else $error("capture flag cleared by a write");
   a_compare_write_clears: assert property (
      tmr_arm_q[1] && wr && idx == `TSI_IDX_CMP_LOW && !compare_evt |=> !tmr_flag_q[1])
      else $error("compare flag survived compare low write");
   a_overflow_write_clears: assert property (
      tmr_arm_q[0] && wr && idx == `TSI_IDX_CNT_LOW && !overflow_evt |=> !tmr_flag_q[0])
      else $error("overflow flag survived counter low write");
   a_serial_write_clears: assert property (
      ser_arm_q && wr && idx == `TSI_IDX_SER_DATA && !serial_done_evt |=> !ser_flag_q)
      else $error("serial flag survived data write");
   a_serial_read_clears: assert property (
      ser_arm_q && rd && idx == `TSI_IDX_SER_DATA && !serial_done_evt |=> !ser_flag_q)
      else $error("serial flag survived data read");
   a_compare_clear: assert property (
      tmr_arm_q[1] && acc && idx == `TSI_IDX_CMP_LOW && !compare_evt |=> !tmr_flag_q[1])
      else $error("compare flag survived compare low access");
   a_overflow_clear: assert property (
      tmr_arm_q[0] && acc && idx == `TSI_IDX_CNT_LOW && !overflow_evt |=> !tmr_flag_q[0])
      else $error("overflow flag survived counter low access");
   a_serial_clear: assert property (
      ser_arm_q && ser_data_acc && !serial_done_evt |=> !ser_flag_q)
      else $error("serial flag survived data access");
   a_serial_w1c: assert property (ser_w1c && !serial_done_evt |=> !ser_flag_q)
      else $error("serial flag survived clear bit write");
   a_arm_needs_flag: assert property (
      rd && idx == `TSI_IDX_TMR_STAT |=> tmr_arm_q == $past(tmr_flag_q))
      else $error("timer clear armed without flag");
   a_serial_arm: assert property (
      rd && idx == `TSI_IDX_SER_STAT |=> ser_arm_q == $past(ser_flag_q))
      else $error("serial clear armed without flag");
   a_unarmed_keeps_flag: assert property (
      !tmr_arm_q[2] && rd && idx == `TSI_IDX_CAP_LOW && tmr_flag_q[2] |=> tmr_flag_q[2])
      else $error("capture flag cleared without arming");
   a_compare_unarmed: assert property (
      !tmr_arm_q[1] && acc && idx == `TSI_IDX_CMP_LOW && tmr_flag_q[1] |=> tmr_flag_q[1])
      else $error("compare flag cleared without arming");
   a_overflow_unarmed: assert property (
      !tmr_arm_q[0] && acc && idx == `TSI_IDX_CNT_LOW && tmr_flag_q[0] |=> tmr_flag_q[0])
      else $error("overflow flag cleared without arming");
   a_serial_unarmed: assert property (
      !ser_arm_q && ser_data_acc && ser_flag_q && !ser_w1c |=> ser_flag_q)
      else $error("serial flag cleared without arming");

   // an event beats a clear in the same cycle
   a_set_wins: assert property (capture_evt |=> tmr_flag_q[2])
      else $error("capture event lost");
   a_compare_set_wins: assert property (compare_evt |=> tmr_flag_q[1])
      else $error("compare event lost");
   a_overflow_set_wins: assert property (overflow_evt |=> tmr_flag_q[0])
      else $error("overflow event lost");
   a_serial_set_wins: assert property (serial_done_evt |=> ser_flag_q)
      else $error("serial event lost");
   a_pending_held: assert property (
      $fell(cpu_irq_mask) && |(tmr_flag_q & tmr_en_q) |-> timer_irq)
      else $error("pending timer request lost under mask");
   a_timer_combined: assert property (timer_irq |-> |(tmr_flag_q & tmr_en_q))
      else $error("timer request without enabled flag");
   a_serial_gated: assert property (serial_irq |-> ser_flag_q && ser_en_q)
      else $error("serial request without enabled flag");
   a_serial_pending: assert property (
      $fell(cpu_irq_mask) && ser_flag_q && ser_en_q |-> serial_irq)
      else $error("pending serial request lost under mask");
   a_flags_reset: assert property (disable iff (1'b0) srst |=> tmr_flag_q == '0 && !ser_flag_q)
      else $error("flags survived reset");

endmodule

// *** tsi_cpu_model.sv ***
// cpu-side bus master model for the timer/serial interrupt block
`timescale 1ns/100ps
module tsi_cpu_model
   import tsi_pkg::*;
(
   input  wire logic        clock,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   logic [31:0] rd_data;
   event        rd_done;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input tsi_idx_t idx, input tsi_byte_t d);
      hsel <= 1'b1;
      haddr <= {24'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      // data lines keep toggling when no write data is due
      hwdata <= w ? {24'h0, d} : ~hwdata;
      do @(posedge clock); while (hready !== 1'b1);
      if (!w) begin
         rd_data = hrdata;
         -> rd_done;
      end
   endtask
endmodule

// *** tsi_irq_bench.sv ***
// self-checking bench for the timer/serial interrupt block
`timescale 1ns/100ps
`include "tsi_defines.svh"
module tsi_irq_bench
   import tsi_pkg::*;
;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        cpu_irq_mask = 1'b0;
   logic [3:0]  evt = 4'h0;
   tsi_byte_t   cap_v = 8'h00, cnt_v = 8'h00, rx_v = 8'h00, b;
   wire logic   hsel, hwrite, hready, hresp, timer_irq, serial_irq, event_irq;
   wire logic [1:0]  htrans;
   wire logic [2:0]  hsize;
   wire logic [31:0] haddr, hwdata, hrdata;
   wire logic        tx_load;
   wire logic [7:0]  cmp_low, tx_data;
   int          fail_count = 0;
   int          samples_checked = 0;
   logic [31:0] seed = 32'h4182;
   tsi_byte_t   rd_q[$];
   logic [2:0]  irq_q[$];
   event        irq_look;
   tsi_byte_t   tx_q[$];
   tsi_byte_t   cl_q[$];
   event        cl_look;

   always #2.5 clock = ~clock;

   tsi_cpu_model cpu (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   tsi_irq uut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .cpu_irq_mask(cpu_irq_mask), .capture_evt(evt[0]), .compare_evt(evt[1]), .overflow_evt(evt[2]),
      .serial_done_evt(evt[3]), .capture_value(cap_v), .counter_value(cnt_v), .serial_rx_data(rx_v),
      .compare_low_byte(cmp_low), .serial_tx_data(tx_data), .serial_tx_load(tx_load), .timer_irq(timer_irq),
      .serial_irq(serial_irq), .event_irq(event_irq));

   function automatic tsi_byte_t xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] got, input tsi_byte_t exp);
      samples_checked++;
      if (got !== {24'h0, exp} || hresp !== 1'b0) begin
         fail_count++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_irq(input logic [2:0] got, input logic [2:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t irq timer/serial/event %b expected %b", $time, got, exp);
      end
   endtask

   task automatic cmp_byte(input tsi_byte_t got, input tsi_byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t output byte %h expected %h", $time, got, exp);
      end
   endtask

   always @(cpu.rd_done) cmp_rd(cpu.rd_data, rd_q.pop_front());
   always @(irq_look) cmp_irq({timer_irq, serial_irq, event_irq}, irq_q.pop_front());
   always @(cl_look) cmp_byte(cmp_low, cl_q.pop_front());
   always @(negedge clock) if (tx_load === 1'b1) cmp_byte(tx_data, tx_q.pop_front());

   task automatic wr(input tsi_idx_t idx, input tsi_byte_t d);
      cpu.xfer(1'b1, idx, d);
   endtask
   task automatic rd(input tsi_idx_t idx, input tsi_byte_t exp);
      rd_q.push_back(exp);
      cpu.xfer(1'b0, idx, 8'h00);
   endtask
   task automatic chk_irq(input logic [2:0] exp);
      #1;
      irq_q.push_back(exp);
      -> irq_look;
      @(posedge clock);
   endtask
   task automatic chk_cmp_low(input tsi_byte_t exp);
      #1;
      cl_q.push_back(exp);
      -> cl_look;
      @(posedge clock);
   endtask
   task automatic pulse(input logic [3:0] bits);
      evt <= bits;
      @(posedge clock);
      evt <= 4'h0;
      @(posedge clock);
   endtask

   initial begin
      #20000;
      fail_count++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(`TSI_IDX_SER_CTRL, 8'h00);
      rd(`TSI_IDX_SER_STAT, 8'h00);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      rd(`TSI_IDX_CMP_LOW, 8'h00);
      rd(`TSI_IDX_EVT_MASK, 8'h00);
      wr(6'h3f, 8'hff);
      rd(6'h3f, 8'h00);
      wr(`TSI_IDX_TMR_CTRL, 8'he0);
      pulse(4'h7);
      chk_irq(3'b100);
      rd(`TSI_IDX_EVT_STAT, 8'h07);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(`TSI_IDX_TMR_CTRL, 8'he0);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      rd(`TSI_IDX_EVT_STAT, 8'h00);
      b = xs();
      cap_v <= b;
      wr(`TSI_IDX_TMR_CTRL, 8'h60);
      pulse(4'h1);
      chk_irq(3'b000);
      wr(`TSI_IDX_TMR_CTRL, 8'he0);
      chk_irq(3'b100);
      rd(`TSI_IDX_CAP_LOW, b);
      rd(`TSI_IDX_TMR_STAT, 8'h80);
      wr(`TSI_IDX_CAP_LOW, 8'hff);
      rd(`TSI_IDX_CAP_LOW, b);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      pulse(4'h1);
      rd(`TSI_IDX_CAP_LOW, b);
      rd(`TSI_IDX_TMR_STAT, 8'h80);
      rd(`TSI_IDX_CAP_LOW, b);
      chk_irq(3'b000);
      b = xs();
      cpu_irq_mask <= 1'b1;
      pulse(4'h2);
      chk_irq(3'b000);
      cpu_irq_mask <= 1'b0;
      chk_irq(3'b100);
      rd(`TSI_IDX_CMP_LOW, 8'h00);
      rd(`TSI_IDX_TMR_STAT, 8'h40);
      wr(`TSI_IDX_CMP_LOW, b);
      chk_cmp_low(b);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      rd(`TSI_IDX_CMP_LOW, b);
      cnt_v <= xs();
      pulse(4'h4);
      chk_irq(3'b100);
      rd(`TSI_IDX_TMR_STAT, 8'h20);
      wr(`TSI_IDX_CNT_LOW, 8'h55);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      pulse(4'h4);
      rd(`TSI_IDX_CNT_LOW, cnt_v);
      rd(`TSI_IDX_TMR_STAT, 8'h20);
      rd(`TSI_IDX_CNT_LOW, cnt_v);
      rd(`TSI_IDX_TMR_STAT, 8'h00);
      rx_v <= xs();
      wr(`TSI_IDX_SER_CTRL, 8'h80);
      pulse(4'h8);
      chk_irq(3'b010);
      cpu_irq_mask <= 1'b1;
      chk_irq(3'b000);
      cpu_irq_mask <= 1'b0;
      rd(`TSI_IDX_SER_STAT, 8'h80);
      b = xs();
      tx_q.push_back(b);
      wr(`TSI_IDX_SER_DATA, b);
      rd(`TSI_IDX_SER_STAT, 8'h00);
      pulse(4'h8);
      rd(`TSI_IDX_SER_DATA, rx_v);
      rd(`TSI_IDX_SER_STAT, 8'h80);
      rd(`TSI_IDX_SER_DATA, rx_v);
      rd(`TSI_IDX_SER_STAT, 8'h00);
      pulse(4'h8);
      wr(`TSI_IDX_SER_CTRL, 8'h81);
      rd(`TSI_IDX_SER_STAT, 8'h00);
      rd(`TSI_IDX_SER_CTRL, 8'h80);
      chk_irq(3'b000);
      rd(`TSI_IDX_EVT_STAT, 8'h0f);
      wr(`TSI_IDX_EVT_MASK, 8'h08);
      chk_irq(3'b001);
      wr(`TSI_IDX_EVT_STAT, 8'h08);
      chk_irq(3'b000);
      rd(`TSI_IDX_EVT_STAT, 8'h07);
      @(posedge clock);
      if (rd_q.size() != 0 || irq_q.size() != 0 || tx_q.size() != 0 || cl_q.size() != 0) begin
         fail_count++;
         $display("BAD %0t expected results left unchecked", $time);
      end
      close_out();
   end
endmodule
